// ---- inc/clock_select_regs.vh ----
// Purpose: Register map, field codes and reset values of the clock select block
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes: Definitions only
`ifndef CLOCK_SELECT_REGS_VH
`define CLOCK_SELECT_REGS_VH

// ************************************************************
// Register byte addresses
// ************************************************************
`define ADDR_PERIPHERAL_RESET_CTRL_B 32'h4004_808c
`define ADDR_UART_A_CLOCK_SOURCE 32'h4004_8090
`define ADDR_UART_B_CLOCK_SOURCE 32'h4004_8094
`define ADDR_I2C_CLOCK_SOURCE 32'h4004_80a4
`define ADDR_SPI_CLOCK_SOURCE 32'h4004_80b4
`define ADDR_FRAC_GEN_DENOMINATOR 32'h4004_80d0
`define ADDR_FRAC_GEN_NUMERATOR 32'h4004_80d4
`define ADDR_FRAC_GEN_SOURCE 32'h4004_80d8
`define ADDR_CLOCK_OUTPUT_SOURCE 32'h4004_80f0

// ************************************************************
// Fields and reset values
// ************************************************************
`define FRAC_GEN_RESET_BIT 3
`define RESET_CTRL_B_RESERVED 32'hffff_fff7
`define FUNC_SEL_RESET 3'h7
`define FRAC_SRC_RESET 2'h0
`define CLOCK_OUT_SEL_RESET 3'h0
`define FRAC_FIELD_RESET 8'h00

// ************************************************************
// Source codes
// ************************************************************
`define FUNC_SEL_FAST_OSC 3'h0
`define FUNC_SEL_MAIN 3'h1
`define FUNC_SEL_FRAC 3'h2
`define FUNC_SEL_FAST_HALVED 3'h4
`define FRAC_SRC_FAST_OSC 2'h0
`define FRAC_SRC_MAIN 2'h1
`define CLOCK_OUT_SEL_FAST_OSC 3'h0
`define CLOCK_OUT_SEL_MAIN 3'h1
`define CLOCK_OUT_SEL_EXTERNAL 3'h3
`define CLOCK_OUT_SEL_LOW_POWER 3'h4

// ************************************************************
// Bus responses
// ************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- core/periph_clock_select_frac_gen.v ----
// Purpose: Peripheral function clock selectors, fractional rate generator, clock output select
// Assumes: Source clock levels are sampled as synchronous inputs of clock
// Notes: Every clock output is registered from the selected source level
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "clock_select_regs.vh"

// Function
// R1: Assigned reset bits hold peripheral in reset at 0, release at 1.
// R2: Bit 3 drives the active-low fractional generator reset, resets to 1.
// R3: Separate selectors for first UART, second UART, I2C and SPI.
// R4: Codes 0 fast, 1 main, 2 fractional, 4 halved; others none; reset 7.
// R5: Fractional output equals source divided by one plus numerator over denominator.
// R6: Denominator is divider field plus one; field resets to zero.
// R7: Software must program divider 0xFF for denominator 256.
// R8: Numerator field used directly, resets zero, source passes undivided.
// R9: Fractional source code 0 fast, 1 main, 2 and 3 none; reset 0.
// R10: Clock output codes 0 fast, 1 main, 3 external, 4 low power; reset 0.
// R11: No-clock or reserved codes hold the output static low.
module periph_clock_select_frac_gen
(
  // Clock and reset
  input wire clock,
  input wire rst,
  // AXI4-Lite write address
  input wire awvalid,
  output reg awready,
  input wire [31:0] awaddr,
  input wire [2:0] awprot,
  // AXI4-Lite write data
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address
  input wire arvalid,
  output reg arready,
  input wire [31:0] araddr,
  input wire [2:0] arprot,
  // AXI4-Lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Source clocks
  input wire internalFastOsc,
  input wire internalFastOscHalved,
  input wire mainClock,
  input wire externalClock,
  input wire lowPowerOsc,
  // Generated clocks and resets
  output reg fracGenResetN,
  output reg fracRateGen,
  output wire uartAClock,
  output wire uartBClock,
  output wire i2cClock,
  output wire spiClock,
  output reg clockOutputPin
);

  // ************************************************************
  // Register state
  // ************************************************************
  reg [2:0] funcSel [0:3];
  reg [7:0] fracDenominatorField;
  reg [7:0] fracNumerator;
  reg [1:0] fracSource;
  reg [2:0] clockOutputSel;
  reg [3:0] functionClockMux;

  reg awHeld;
  reg wHeld;
  reg [31:0] writeAddr;
  reg [31:0] writeData;
  reg writeLane0;

  function addrMapped;
    input [31:0] addr;
    begin
      case (addr)
        `ADDR_PERIPHERAL_RESET_CTRL_B, `ADDR_UART_A_CLOCK_SOURCE,
        `ADDR_UART_B_CLOCK_SOURCE, `ADDR_I2C_CLOCK_SOURCE,
        `ADDR_SPI_CLOCK_SOURCE, `ADDR_FRAC_GEN_DENOMINATOR,
        `ADDR_FRAC_GEN_NUMERATOR, `ADDR_FRAC_GEN_SOURCE,
        `ADDR_CLOCK_OUTPUT_SOURCE: addrMapped = 1'b1;
        default: addrMapped = 1'b0;
      endcase
    end
  endfunction

  reg [31:0] readValue;
  always @*
  begin
    case (araddr)
      `ADDR_PERIPHERAL_RESET_CTRL_B:
        readValue = `RESET_CTRL_B_RESERVED | {28'h000_0000, fracGenResetN, 3'h0};
      `ADDR_UART_A_CLOCK_SOURCE: readValue = {29'h0000_0000, funcSel[0]};
      `ADDR_UART_B_CLOCK_SOURCE: readValue = {29'h0000_0000, funcSel[1]};
      `ADDR_I2C_CLOCK_SOURCE: readValue = {29'h0000_0000, funcSel[2]};
      `ADDR_SPI_CLOCK_SOURCE: readValue = {29'h0000_0000, funcSel[3]};
      `ADDR_FRAC_GEN_DENOMINATOR: readValue = {24'h00_0000, fracDenominatorField};
      `ADDR_FRAC_GEN_NUMERATOR: readValue = {24'h00_0000, fracNumerator};
      `ADDR_FRAC_GEN_SOURCE: readValue = {30'h0000_0000, fracSource};
      `ADDR_CLOCK_OUTPUT_SOURCE: readValue = {29'h0000_0000, clockOutputSel};
      default: readValue = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  // One write and one read at a time; unmapped addresses answer SLVERR
  always @(posedge clock)
  begin
    if (rst)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      writeAddr <= 32'h0000_0000;
      writeData <= 32'h0000_0000;
      writeLane0 <= 1'b0;
      fracGenResetN <= 1'b1; // R2
      funcSel[0] <= `FUNC_SEL_RESET; // R4
      funcSel[1] <= `FUNC_SEL_RESET;
      funcSel[2] <= `FUNC_SEL_RESET;
      funcSel[3] <= `FUNC_SEL_RESET;
      fracDenominatorField <= `FRAC_FIELD_RESET; // R6
      fracNumerator <= `FRAC_FIELD_RESET; // R8
      fracSource <= `FRAC_SRC_RESET; // R9
      clockOutputSel <= `CLOCK_OUT_SEL_RESET; // R10
    end
    else
    begin
      if (awvalid && awready)
      begin
        writeAddr <= awaddr;
        awHeld <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        writeData <= wdata;
        writeLane0 <= wstrb[0];
        wHeld <= 1'b1;
        wready <= 1'b0;
      end
      if (awHeld && wHeld && !bvalid)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= addrMapped(writeAddr) ? `RESP_OKAY : `RESP_SLVERR;
        if (writeLane0)
        begin
          case (writeAddr)
            `ADDR_PERIPHERAL_RESET_CTRL_B:
              fracGenResetN <= writeData[`FRAC_GEN_RESET_BIT]; // R1
            `ADDR_UART_A_CLOCK_SOURCE: funcSel[0] <= writeData[2:0]; // R3
            `ADDR_UART_B_CLOCK_SOURCE: funcSel[1] <= writeData[2:0];
            `ADDR_I2C_CLOCK_SOURCE: funcSel[2] <= writeData[2:0];
            `ADDR_SPI_CLOCK_SOURCE: funcSel[3] <= writeData[2:0];
            `ADDR_FRAC_GEN_DENOMINATOR: fracDenominatorField <= writeData[7:0];
            `ADDR_FRAC_GEN_NUMERATOR: fracNumerator <= writeData[7:0];
            `ADDR_FRAC_GEN_SOURCE: fracSource <= writeData[1:0];
            `ADDR_CLOCK_OUTPUT_SOURCE: clockOutputSel <= writeData[2:0];
            default: clockOutputSel <= clockOutputSel;
          endcase
        end
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (arvalid && arready)
      begin
        rdata <= readValue;
        rresp <= addrMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        rvalid <= 1'b1;
        arready <= 1'b0;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Fractional rate generator
  // ************************************************************
  // Each source rising edge is passed or swallowed; a passed edge adds the
  // numerator to the credit, a swallowed one removes the denominator, so
  // D of every D+M source periods reach the output.
  reg fracSrcLevel;
  reg fracSrcPrev;
  reg passGate;
  reg [9:0] credit;
  wire [9:0] denominator = {2'b00, fracDenominatorField} + 10'h001; // R6
  wire srcRise = fracSrcLevel & ~fracSrcPrev;
  wire passNow = credit < denominator;

  always @*
  begin
    case (fracSource) // R9
      `FRAC_SRC_FAST_OSC: fracSrcLevel = internalFastOsc;
      `FRAC_SRC_MAIN: fracSrcLevel = mainClock;
      default: fracSrcLevel = 1'b0; // R11
    endcase
  end

  always @(posedge clock)
  begin
    if (rst || !fracGenResetN) // R1 R2
    begin
      fracSrcPrev <= 1'b0;
      passGate <= 1'b0;
      credit <= 10'h000;
      fracRateGen <= 1'b0;
    end
    else
    begin
      fracSrcPrev <= fracSrcLevel;
      if (srcRise)
      begin
        passGate <= passNow;
        if (passNow)
          credit <= credit + {2'b00, fracNumerator}; // R8
        else
          credit <= credit - denominator; // R5
      end
      fracRateGen <= fracSrcLevel & (srcRise ? passNow : passGate); // R5
    end
  end

  // ************************************************************
  // Function clock multiplexers
  // ************************************************************
  // Selector changes are not glitch protected: a short pulse may show at
  // the switch, so change a selector only while its peripheral idles.
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : gen_func
      always @(posedge clock)
      begin
        if (rst)
          functionClockMux[i] <= 1'b0;
        else
        begin
          case (funcSel[i]) // R4
            `FUNC_SEL_FAST_OSC: functionClockMux[i] <= internalFastOsc;
            `FUNC_SEL_MAIN: functionClockMux[i] <= mainClock;
            `FUNC_SEL_FRAC: functionClockMux[i] <= fracRateGen;
            `FUNC_SEL_FAST_HALVED: functionClockMux[i] <= internalFastOscHalved;
            default: functionClockMux[i] <= 1'b0; // R11
          endcase
        end
      end
    end
  endgenerate

  assign uartAClock = functionClockMux[0]; // R3
  assign uartBClock = functionClockMux[1];
  assign i2cClock = functionClockMux[2];
  assign spiClock = functionClockMux[3];

  // ************************************************************
  // Clock output pin multiplexer
  // ************************************************************
  always @(posedge clock)
  begin
    if (rst)
      clockOutputPin <= 1'b0;
    else
    begin
      case (clockOutputSel) // R10
        `CLOCK_OUT_SEL_FAST_OSC: clockOutputPin <= internalFastOsc;
        `CLOCK_OUT_SEL_MAIN: clockOutputPin <= mainClock;
        `CLOCK_OUT_SEL_EXTERNAL: clockOutputPin <= externalClock;
        `CLOCK_OUT_SEL_LOW_POWER: clockOutputPin <= lowPowerOsc;
        default: clockOutputPin <= 1'b0; // R11
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- bench/clock_select_monitor.sv ----
// Purpose: Port-level checks of bus handshakes and clock outputs
// Assumes: Synchronous active-high reset
// Notes: Bound to the top module
`timescale 1ns/1ns
`default_nettype none
module clock_select_monitor
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Clocks
  input wire logic fracGenResetN,
  input wire logic fracRateGen,
  input wire logic uartAClock,
  input wire logic uartBClock,
  input wire logic i2cClock,
  input wire logic spiClock,
  input wire logic clockOutputPin
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  reset_idle_a: assert property (disable iff (1'b0) rst |=> awready && wready
    && arready && !bvalid && !rvalid && fracGenResetN) else $error("not idle after reset");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !uartAClock && !uartBClock
    && !i2cClock && !spiClock && !fracRateGen && !clockOutputPin) else $error("clock active");
  frac_hold_a: assert property (!fracGenResetN && !$past(fracGenResetN) |-> !fracRateGen)
    else $error("generator runs in reset");
  read_answer_a: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
  read_done_a: assert property (rvalid && rready |=> !rvalid && arready) else $error("read stuck");
  write_done_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write stuck");
  read_block_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
  write_block_a: assert property (bvalid |-> !awready && !wready) else $error("write overlap");
  unmapped_read_a: assert property (arvalid && arready && araddr == 32'h0000_0000
    |=> rresp == 2'h2 && rdata == 32'h0000_0000) else $error("unmapped read not refused");
  cover property (arvalid && arready);
  cover property (bvalid && bready);
  cover property ($rose(fracRateGen));
endmodule
bind periph_clock_select_frac_gen clock_select_monitor i_clock_select_monitor (.clock, .rst,
  .awready, .wready, .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
  .rresp, .fracGenResetN, .fracRateGen, .uartAClock, .uartBClock, .i2cClock, .spiClock,
  .clockOutputPin);
`default_nettype wire

// ---- bench/periph_clock_select_frac_gen_tb_top.sv ----
// Purpose: Register and clock selection tests over AXI4-Lite
// Assumes: Source clocks are slow counter bits of clock
// Notes: Output rates are judged by edge counts over whole source periods
`timescale 1ns/1ns
`default_nettype none
`include "clock_select_regs.vh"
module periph_clock_select_frac_gen_tb_top;
  logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, got;
  logic awready, wready, bvalid, arready, rvalid, fracGenResetN, fracRateGen;
  logic uartAClock, uartBClock, i2cClock, spiClock, clockOutputPin;
  logic [1:0] bresp, rresp, resp;
  logic [5:0] cnt = 6'h00;
  logic [5:0] outs;
  int nErrors, cmpCount, n;
  int fexp[8] = '{16, 4, 16, 0, 8, 0, 0, 0};
  int oexp[8] = '{16, 4, 0, 2, 1, 0, 0, 0};
  int sexp[4] = '{16, 4, 0, 0};
  logic [31:0] fsel[4] = '{`ADDR_UART_A_CLOCK_SOURCE, `ADDR_UART_B_CLOCK_SOURCE,
    `ADDR_I2C_CLOCK_SOURCE, `ADDR_SPI_CLOCK_SOURCE};
  logic [31:0] radr[9] = '{`ADDR_PERIPHERAL_RESET_CTRL_B, `ADDR_UART_A_CLOCK_SOURCE,
    `ADDR_UART_B_CLOCK_SOURCE, `ADDR_I2C_CLOCK_SOURCE, `ADDR_SPI_CLOCK_SOURCE,
    `ADDR_FRAC_GEN_DENOMINATOR, `ADDR_FRAC_GEN_NUMERATOR, `ADDR_FRAC_GEN_SOURCE,
    `ADDR_CLOCK_OUTPUT_SOURCE};
  logic [31:0] rval[9] = '{32'hffff_ffff, 32'h0000_0007, 32'h0000_0007, 32'h0000_0007,
    32'h0000_0007, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  assign outs = {clockOutputPin, fracRateGen, spiClock, i2cClock, uartBClock, uartAClock};
  periph_clock_select_frac_gen i_periph_clock_select_frac_gen (.clock, .rst, .awvalid,
    .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
    .rresp, .internalFastOsc(cnt[1]), .internalFastOscHalved(cnt[2]), .mainClock(cnt[3]),
    .externalClock(cnt[4]), .lowPowerOsc(cnt[5]), .fracGenResetN, .fracRateGen,
    .uartAClock, .uartBClock, .i2cClock, .spiClock, .clockOutputPin);
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cnt <= cnt + 6'h01;
  task summarize;
    $display("compares %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] g, e);
    cmpCount++;
    if (g !== e)
    begin
      nErrors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [31:0] a, d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
    // Let an edge pass so the next call never reassigns bready in this step
    @(posedge clock);
  endtask
  task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge clock);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
    // Let an edge pass so the next call never reassigns rready in this step
    @(posedge clock);
  endtask
  task set(input logic [31:0] a, d);
    wr(a, d, resp);
    chk("bresp", resp, 0);
    rd(a, got, resp);
    chk("readback", got, d);
  endtask
  // Counts rising edges of one clock output over a window
  task meas(input int i, w, e);
    logic p;
    repeat (4) @(posedge clock);
    #1 p = outs[i];
    n = 0;
    repeat (w)
    begin
      @(posedge clock);
      #1 if (outs[i] && !p) n++;
      p = outs[i];
    end
    chk("edges", n, e);
    @(posedge clock);
  endtask
  initial
  begin
    rst = 1;
    awvalid = 0;
    wvalid = 0;
    bready = 0;
    arvalid = 0;
    rready = 0;
    awaddr = 0;
    wdata = 0;
    araddr = 0;
    repeat (2) @(posedge clock);
    rst <= 0;
    for (int k = 0; k < 9; k++)
    begin
      rd(radr[k], got, resp);
      chk("reset value", got, rval[k]);
    end
    wr(32'h0000_0000, 32'h0000_0001, resp);
    chk("unmapped bresp", resp, 2);
    rd(32'h0000_0000, got, resp);
    chk("unmapped rresp", resp, 2);
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 8; c++)
      begin
        set(fsel[s], c);
        meas(s, 64, fexp[c]);
        meas((s + 1) % 4, 64, 0);
      end
    for (int c = 0; c < 4; c++)
    begin
      set(`ADDR_FRAC_GEN_SOURCE, c);
      meas(4, 64, sexp[c]);
    end
    set(`ADDR_FRAC_GEN_SOURCE, 0);
    set(`ADDR_FRAC_GEN_DENOMINATOR, 32'h0000_00ff);
    set(`ADDR_FRAC_GEN_NUMERATOR, 32'h0000_0080);
    meas(4, 12288, 2048);
    set(`ADDR_PERIPHERAL_RESET_CTRL_B, 32'hffff_fff7);
    chk("frac reset line", fracGenResetN, 0);
    meas(4, 64, 0);
    set(`ADDR_PERIPHERAL_RESET_CTRL_B, 32'hffff_ffff);
    chk("frac reset line", fracGenResetN, 1);
    meas(4, 192, 32);
    for (int c = 0; c < 8; c++)
    begin
      set(`ADDR_CLOCK_OUTPUT_SOURCE, c);
      meas(5, 64, oexp[c]);
    end
    summarize;
  end
  initial
  begin
    #1000000;
    nErrors++;
    summarize;
  end
endmodule
`default_nettype wire
